// ===== hw/eer_pkg.sv
`default_nettype none
package eer_pkg;
   // Object dictionary indices
   localparam logic [15:0] IDX_ERROR_BYTE     = 16'h1001;
   localparam logic [15:0] IDX_MFR_ERROR_WORD = 16'h1002;
   localparam logic [15:0] IDX_ERROR_HISTORY  = 16'h1003;
   localparam logic [15:0] IDX_INHIBIT_TIME   = 16'h1015;
   localparam logic [7:0]  SUB_ZERO           = 8'h00;
   localparam int          HISTORY_DEPTH      = 5;
   localparam logic [7:0]  HISTORY_MAX        = 8'h05;

   // Manufacturer error word bit positions
   localparam int BIT_GUARD      = 15;
   localparam int BIT_RX_OVERRUN = 10;
   localparam int BIT_BUS_OFF    = 9;
   localparam int BIT_WARNING    = 8;
   localparam int BIT_SELF_TEST  = 7;
   localparam int BIT_CRC        = 4;
   localparam int BIT_TEMP       = 3;
   localparam int BIT_Y_AXIS     = 2;
   localparam int BIT_X_AXIS     = 1;
   localparam logic [31:0] MFR_WORD_RESET = 32'h0000_0000;

   // One-byte error register bit positions
   localparam int EB_ANY     = 0;
   localparam int EB_TEMP    = 3;
   localparam int EB_COMM    = 4;
   localparam int EB_PROFILE = 5;
   localparam int EB_HW      = 7;

   // Error codes
   localparam logic [15:0] CODE_RESET     = 16'h0000;
   localparam logic [15:0] CODE_GENERIC   = 16'h1030;
   localparam logic [15:0] CODE_TEMP      = 16'h4200;
   localparam logic [15:0] CODE_HW        = 16'h5000;
   localparam logic [15:0] CODE_X_AXIS    = 16'h5010;
   localparam logic [15:0] CODE_Y_AXIS    = 16'h5020;
   localparam logic [15:0] CODE_OVERFLOW  = 16'h8110;
   localparam logic [15:0] CODE_WARNING   = 16'h8120;
   localparam logic [15:0] CODE_GUARD     = 16'h8130;
   localparam logic [15:0] CODE_BUS_OFF   = 16'h8140;

   localparam logic [10:0] EMCY_ID_BASE   = 11'h080;
   localparam logic [15:0] INHIBIT_RESET  = 16'h0000;

   // Inhibit unit timing
   localparam int INHIBIT_UNIT_NS = 100000;
   localparam int CLK_PERIOD_NS   = 8;
   localparam int INHIBIT_UNIT_CYCLES = INHIBIT_UNIT_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic guardErr;
      logic rxOverrun;
      logic busOff;
      logic canWarning;
      logic selfTestFault;
      logic crcFault;
      logic tempErr;
      logic yRange;
      logic xRange;
   } eer_cond_t;

   typedef struct packed {
      logic [10:0] cobId;
      logic [63:0] data;
   } eer_frame_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] index;
      logic [7:0]  sub;
      logic [31:0] wdata;
   } eer_od_req_t;
endpackage
`default_nettype wire

// ===== hw/eer_error_reporter.sv
// Functional notes
// - Live 32-bit error word tracks conditions
// - Word: zeros, comm field, device field
// - Comm bits: guard, overrun, bus-off, warning
// - Device bits: self-test, CRC, temperature
// - Device bits 1/2 flag X/Y range
// - Low 16 word bits go into emergency
// - History: count plus five newest entries
// - New event shifts history, oldest dropped
// - Entry: fields high, code low
// - Device-side error code values
// - Communication error code values
// - New error queues an emergency message
// - Clearing sends error-reset emergency
// - Emergency identifier is 80h plus node
// - Payload: code, byte, comm, device, zeros
// - Error code low byte first
// - Inhibit time spaces emergencies, 100 us units
// - Range error sets byte bits 5, 0
// - Byte bits 0, 3, 7 meanings
// - Byte bit 4 on communication error
`timescale 1ns/100ps
`default_nettype none
module eer_error_reporter #(
   parameter int INHIBIT_UNIT_CYCLES = eer_pkg::INHIBIT_UNIT_CYCLES
) (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire eer_pkg::eer_cond_t   cond,
   input  wire logic [6:0]           nodeId,
   input  wire eer_pkg::eer_od_req_t odReq,
   output logic                      odAck,
   output logic                      odError,
   output logic [31:0]               odRdata,
   output eer_pkg::eer_frame_t       emcyFrame,
   output logic                      emcyValid,
   input  wire logic                 emcyReady,
   output logic [31:0]               mfrErrorWord,
   output logic [7:0]                errorByte
);

   logic [31:0] history [1:eer_pkg::HISTORY_DEPTH];
   logic [7:0]  histCount;
   logic [15:0] inhibitTime;
   logic [15:0] inhibitLeft;
   logic [31:0] tickCnt;
   logic        tick;
   logic        eventSeen;
   logic        pending;
   logic [15:0] pendCode;
   logic [31:0] next_word;
   logic [7:0]  next_byte;
   logic [31:0] rising;
   logic        newEvent;
   logic [15:0] eventCode;
   logic        inhibitBusy;

   // Highest priority newly set condition picks the code
   function automatic logic [15:0] pickCode(input logic [31:0] r);
      logic [15:0] c;
      c = eer_pkg::CODE_GENERIC;
      if (r[eer_pkg::BIT_SELF_TEST] || r[eer_pkg::BIT_CRC])
         c = eer_pkg::CODE_HW;
      else if (r[eer_pkg::BIT_TEMP])
         c = eer_pkg::CODE_TEMP;
      else if (r[eer_pkg::BIT_X_AXIS])
         c = eer_pkg::CODE_X_AXIS;
      else if (r[eer_pkg::BIT_Y_AXIS])
         c = eer_pkg::CODE_Y_AXIS;
      else if (r[eer_pkg::BIT_RX_OVERRUN])
         c = eer_pkg::CODE_OVERFLOW;
      else if (r[eer_pkg::BIT_WARNING])
         c = eer_pkg::CODE_WARNING;
      else if (r[eer_pkg::BIT_GUARD])
         c = eer_pkg::CODE_GUARD;
      else if (r[eer_pkg::BIT_BUS_OFF])
         c = eer_pkg::CODE_BUS_OFF;
      return c;
   endfunction

   always_comb begin
      next_word = 32'h0000_0000;
      next_word[eer_pkg::BIT_GUARD]      = cond.guardErr;
      next_word[eer_pkg::BIT_RX_OVERRUN] = cond.rxOverrun;
      next_word[eer_pkg::BIT_BUS_OFF]    = cond.busOff;
      next_word[eer_pkg::BIT_WARNING]    = cond.canWarning;
      next_word[eer_pkg::BIT_SELF_TEST]  = cond.selfTestFault;
      next_word[eer_pkg::BIT_CRC]        = cond.crcFault;
      next_word[eer_pkg::BIT_TEMP]       = cond.tempErr;
      next_word[eer_pkg::BIT_Y_AXIS]     = cond.yRange;
      next_word[eer_pkg::BIT_X_AXIS]     = cond.xRange;
   end

   always_comb begin
      next_byte = 8'h00;
      next_byte[eer_pkg::EB_ANY]     = |next_word;
      next_byte[eer_pkg::EB_TEMP]    = next_word[eer_pkg::BIT_TEMP];
      next_byte[eer_pkg::EB_COMM]    = |next_word[15:8];
      next_byte[eer_pkg::EB_PROFILE] = next_word[eer_pkg::BIT_X_AXIS] |
                                       next_word[eer_pkg::BIT_Y_AXIS];
      next_byte[eer_pkg::EB_HW]      = next_word[eer_pkg::BIT_SELF_TEST] |
                                       next_word[eer_pkg::BIT_CRC];
   end

   // Any change of the word is an event; pure clearing reports a reset
   always_comb begin
      rising    = next_word & ~mfrErrorWord;
      newEvent  = (next_word != mfrErrorWord);
      eventCode = (|rising) ? pickCode(rising) : eer_pkg::CODE_RESET;
   end

   // Live word and error byte
   always_ff @(posedge clk) begin
      if (reset) begin
         mfrErrorWord <= eer_pkg::MFR_WORD_RESET;
         errorByte    <= 8'h00;
         eventSeen    <= 1'b0;
      end else begin
         mfrErrorWord <= next_word;
         errorByte    <= next_byte;
         eventSeen    <= newEvent;
      end
   end

   // History shift register and count
   always_ff @(posedge clk) begin
      if (reset) begin
         histCount <= 8'h00;
         for (int i = 1; i <= eer_pkg::HISTORY_DEPTH; i++)
            history[i] <= 32'h0000_0000;
      end else if (newEvent) begin
         for (int i = eer_pkg::HISTORY_DEPTH; i > 1; i--)
            history[i] <= history[i-1];
         history[1] <= {next_word[15:0], eventCode};
         if (histCount < eer_pkg::HISTORY_MAX)
            histCount <= histCount + 8'h01;
      end
   end

   // Divider for the 100 us inhibit unit
   always_ff @(posedge clk) begin
      if (reset || !inhibitBusy) begin
         tickCnt <= 32'h0000_0000;
         tick    <= 1'b0;
      end else if (tickCnt == 32'(INHIBIT_UNIT_CYCLES - 1)) begin
         tickCnt <= 32'h0000_0000;
         tick    <= 1'b1;
      end else begin
         tickCnt <= tickCnt + 32'h0000_0001;
         tick    <= 1'b0;
      end
   end

   assign inhibitBusy = (inhibitLeft != 16'h0000);

   // Pending request, latest code wins; held while inhibited
   always_ff @(posedge clk) begin
      if (reset) begin
         pending  <= 1'b0;
         pendCode <= eer_pkg::CODE_RESET;
      end else if (eventSeen) begin
         pending  <= 1'b1;
         pendCode <= history[1][15:0];
      end else if (pending && !emcyValid && !inhibitBusy) begin
         pending  <= 1'b0;
      end
   end

   // Frame builder and inhibit timer
   always_ff @(posedge clk) begin
      if (reset) begin
         emcyValid   <= 1'b0;
         emcyFrame   <= '0;
         inhibitLeft <= 16'h0000;
      end else begin
         if (emcyValid && emcyReady) begin
            emcyValid   <= 1'b0;
            inhibitLeft <= inhibitTime;
         end else if (tick && inhibitBusy) begin
            inhibitLeft <= inhibitLeft - 16'h0001;
         end
         if (pending && !emcyValid && !inhibitBusy && !eventSeen) begin
            emcyValid       <= 1'b1;
            emcyFrame.cobId <= eer_pkg::EMCY_ID_BASE + {4'h0, nodeId};
            emcyFrame.data  <= {pendCode[7:0], pendCode[15:8],
                                errorByte,
                                mfrErrorWord[15:8],
                                mfrErrorWord[7:0],
                                24'h000000};
         end
      end
   end

   // Dictionary access: read data one cycle after the request
   always_ff @(posedge clk) begin
      if (reset) begin
         inhibitTime <= eer_pkg::INHIBIT_RESET;
         odAck       <= 1'b0;
         odError     <= 1'b0;
         odRdata     <= 32'h0000_0000;
      end else begin
         odAck   <= odReq.rd | odReq.wr;
         odError <= 1'b0;
         odRdata <= 32'h0000_0000;
         if (odReq.wr) begin
            if (odReq.index == eer_pkg::IDX_INHIBIT_TIME && odReq.sub == eer_pkg::SUB_ZERO)
               inhibitTime <= odReq.wdata[15:0];
            else
               odError <= 1'b1;
         end else if (odReq.rd) begin
            case (odReq.index)
               eer_pkg::IDX_ERROR_BYTE: begin
                  odRdata <= {24'h000000, errorByte};
                  odError <= (odReq.sub != eer_pkg::SUB_ZERO);
               end
               eer_pkg::IDX_MFR_ERROR_WORD: begin
                  odRdata <= mfrErrorWord;
                  odError <= (odReq.sub != eer_pkg::SUB_ZERO);
               end
               eer_pkg::IDX_ERROR_HISTORY: begin
                  if (odReq.sub == eer_pkg::SUB_ZERO)
                     odRdata <= {24'h000000, histCount};
                  else if (odReq.sub <= eer_pkg::HISTORY_MAX)
                     odRdata <= history[odReq.sub[2:0]];
                  else
                     odError <= 1'b1;
               end
               eer_pkg::IDX_INHIBIT_TIME: begin
                  odRdata <= {16'h0000, inhibitTime};
                  odError <= (odReq.sub != eer_pkg::SUB_ZERO);
               end
               default: odError <= 1'b1;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ===== tb/eer_error_reporter_properties.sv
`timescale 1ns/100ps
`default_nettype none
module eer_error_reporter_properties #(
   parameter int INHIBIT_UNIT_CYCLES = 4
) (
   input wire logic                 clk,
   input wire logic                 reset,
   input wire eer_pkg::eer_cond_t   cond,
   input wire logic [6:0]           nodeId,
   input wire eer_pkg::eer_od_req_t odReq,
   input wire logic                 odAck,
   input wire logic                 odError,
   input wire logic [31:0]          odRdata,
   input wire eer_pkg::eer_frame_t  emcyFrame,
   input wire logic                 emcyValid,
   input wire logic                 emcyReady,
   input wire logic [31:0]          mfrErrorWord,
   input wire logic [7:0]           errorByte
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic inhOn;
   // Emergency latency is unknown while a nonzero inhibit is programmed
   always_ff @(posedge clk) begin
      if (reset) begin
         inhOn <= 1'b0;
      end else if (odReq.wr && odReq.index == eer_pkg::IDX_INHIBIT_TIME && odReq.sub == eer_pkg::SUB_ZERO) begin
         inhOn <= |odReq.wdata[15:0];
      end
   end
   sequence s_fresh;
      !inhOn && !emcyValid && $changed(mfrErrorWord);
   endsequence
   sequence s_stall;
      emcyValid && !emcyReady;
   endsequence
   a_word_spare_zero: assert property ((mfrErrorWord & 32'hFFFF_7861) == 32'h0)
      else $error("unused error word bit set");
   a_word_tracks: assert property ({mfrErrorWord[15], mfrErrorWord[10:7], mfrErrorWord[4:1]} == $past(cond))
      else $error("error word does not follow conditions");
   a_write_refused: assert property (odReq.wr && odReq.index != eer_pkg::IDX_INHIBIT_TIME |=> odAck && odError)
      else $error("write to read-only object accepted");
   a_byte_bits: assert property (errorByte[0] == |mfrErrorWord[15:0] && errorByte[3] == mfrErrorWord[3]
      && errorByte[7] == (mfrErrorWord[7] | mfrErrorWord[4]))
      else $error("error byte bits wrong");
   a_comm_bit: assert property (errorByte[4] == |mfrErrorWord[15:8])
      else $error("communication bit of error byte wrong");
   a_range_profile: assert property (|mfrErrorWord[2:1] |-> errorByte[5] && errorByte[0])
      else $error("range error without profile bit");
   a_frame_held: assert property (s_stall |=> emcyValid && $stable(emcyFrame))
      else $error("frame dropped before acceptance");
   a_frame_id: assert property (emcyValid |-> emcyFrame.cobId == eer_pkg::EMCY_ID_BASE + {4'h0, nodeId}
      && emcyFrame.data[23:0] == 24'h0)
      else $error("frame identifier or tail wrong");
   a_prompt_emcy: assert property (s_fresh |-> ##2 emcyValid)
      else $error("emergency not raised after change");
   a_inhibit_gap: assert property (emcyValid && emcyReady && inhOn |=> (!emcyValid) [*3])
      else $error("emergency sent inside inhibit time");
endmodule
`default_nettype wire

// ===== tb/eer_can_sink.sv
`timescale 1ns/100ps
`default_nettype none
module eer_can_sink (
   input wire logic                clk,
   input wire logic                reset,
   input wire logic                emcyValid,
   input wire eer_pkg::eer_frame_t emcyFrame,
   input wire logic [7:0]          stall,
   output logic                    emcyReady,
   output eer_pkg::eer_frame_t     gotFrame,
   output logic [7:0]              gotCount
);
   logic [7:0] waitCnt;
   // Controller accepts after a programmable stall
   always_ff @(posedge clk) begin
      if (reset) begin
         emcyReady <= 1'b0;
         waitCnt   <= 8'h00;
         gotCount  <= 8'h00;
         gotFrame  <= '0;
      end else if (emcyValid && emcyReady) begin
         emcyReady <= 1'b0;
         waitCnt   <= 8'h00;
         gotFrame  <= emcyFrame;
         gotCount  <= gotCount + 8'h01;
      end else if (emcyValid) begin
         waitCnt   <= waitCnt + 8'h01;
         emcyReady <= waitCnt >= stall;
      end
   end
endmodule
`default_nettype wire

// ===== tb/eer_error_reporter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module eer_error_reporter_tb;
   localparam int UNIT = 4;
   logic                 clk, reset, odAck, odError, emcyValid, emcyReady;
   eer_pkg::eer_cond_t   cond;
   logic [6:0]           nodeId;
   eer_pkg::eer_od_req_t odReq;
   logic [31:0]          odRdata, mfrErrorWord, rd;
   eer_pkg::eer_frame_t  emcyFrame, gotFrame;
   logic [7:0]           errorByte, stall, gotCount;
   int                   miscompares, num_checks, waitN;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   eer_error_reporter #(.INHIBIT_UNIT_CYCLES(UNIT)) i_eer_error_reporter (.clk(clk), .reset(reset),
      .cond(cond), .nodeId(nodeId), .odReq(odReq), .odAck(odAck), .odError(odError), .odRdata(odRdata),
      .emcyFrame(emcyFrame), .emcyValid(emcyValid), .emcyReady(emcyReady), .mfrErrorWord(mfrErrorWord),
      .errorByte(errorByte));
   eer_can_sink i_eer_can_sink (.clk(clk), .reset(reset), .emcyValid(emcyValid), .emcyFrame(emcyFrame),
      .stall(stall), .emcyReady(emcyReady), .gotFrame(gotFrame), .gotCount(gotCount));
   function automatic logic [63:0] pay(input logic [15:0] c, input logic [7:0] b, input logic [15:0] w);
      return {c[7:0], c[15:8], b, w[15:8], w[7:0], 24'h000000};
   endfunction
   task check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task od(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd, input logic e);
      odReq = '{!w, w, idx, sub, wd};
      @(negedge clk);
      rd = odRdata;
      check(odAck, 1'b1);
      check(odError, e);
      odReq = '0;
      // Idle cycle between requests; acknowledge lasts one cycle
      @(negedge clk);
      check(odAck, 1'b0);
   endtask
   task wait_frame;
      logic [7:0] c0;
      c0 = gotCount;
      waitN = 0;
      while (gotCount === c0 && waitN < 300) begin
         @(negedge clk);
         waitN++;
      end
      check(waitN < 300, 1'b1);
   endtask
   task pair(input logic [8:0] bits, input logic [15:0] code, input logic [15:0] w, input logic [7:0] b);
      cond = bits;
      wait_frame;
      check(gotFrame.data, pay(code, b, w));
      od(1'b0, eer_pkg::IDX_ERROR_HISTORY, 8'h01, 32'h0, 1'b0);
      check(rd, {w, code});
      cond = '0;
      wait_frame;
      check(gotFrame.data, 64'h0);
   endtask
   task t_regs;
      od(1'b0, eer_pkg::IDX_MFR_ERROR_WORD, 8'h00, 32'h0, 1'b0);
      check(rd, 32'h0);
      od(1'b1, eer_pkg::IDX_MFR_ERROR_WORD, 8'h00, 32'h1, 1'b1);
      od(1'b0, 16'h2000, 8'h00, 32'h0, 1'b1);
      check(rd, 32'h0);
      od(1'b1, eer_pkg::IDX_INHIBIT_TIME, 8'h00, 32'h2, 1'b0);
      od(1'b0, eer_pkg::IDX_INHIBIT_TIME, 8'h00, 32'h0, 1'b0);
      check(rd, 32'h2);
   endtask
   task t_inhibit;
      cond = 9'h004;
      wait_frame;
      check(gotFrame.data, pay(16'h4200, 8'h09, 16'h0008));
      cond = '0;
      wait_frame;
      check(waitN >= 2 * UNIT, 1'b1);
      check(gotFrame.data, 64'h0);
      od(1'b0, eer_pkg::IDX_ERROR_HISTORY, 8'h00, 32'h0, 1'b0);
      check(rd, 32'h2);
      od(1'b1, eer_pkg::IDX_INHIBIT_TIME, 8'h00, 32'h0, 1'b0);
      repeat (12) @(negedge clk);
   endtask
   task t_axis;
      stall = 8'h03;
      cond = 9'h001;
      wait_frame;
      check(gotFrame.cobId, 11'h08A);
      check(gotFrame.data, 64'h1050_2100_0200_0000);
      check(errorByte, 8'h21);
      check(mfrErrorWord, 32'h0000_0002);
      od(1'b0, eer_pkg::IDX_ERROR_BYTE, 8'h00, 32'h0, 1'b0);
      check(rd, 32'h21);
      cond = '0;
      wait_frame;
      check(gotFrame.data, 64'h0);
      stall = 8'h00;
   endtask
   task t_codes;
      pair(9'h014, 16'h5000, 16'h0088, 8'h89);
      pair(9'h010, 16'h5000, 16'h0080, 8'h81);
      pair(9'h008, 16'h5000, 16'h0010, 8'h81);
      pair(9'h002, 16'h5020, 16'h0004, 8'h21);
      pair(9'h080, 16'h8110, 16'h0400, 8'h11);
      pair(9'h020, 16'h8120, 16'h0100, 8'h11);
      pair(9'h100, 16'h8130, 16'h8000, 8'h11);
      pair(9'h040, 16'h8140, 16'h0200, 8'h11);
      od(1'b0, eer_pkg::IDX_ERROR_HISTORY, 8'h00, 32'h0, 1'b0);
      check(rd, 32'h5);
      od(1'b0, eer_pkg::IDX_ERROR_HISTORY, 8'h04, 32'h0, 1'b0);
      check(rd, 32'h8000_8130);
   endtask
   initial begin
      #300000;
      miscompares++;
      final_report;
   end
   initial begin
      cond = '0;
      nodeId = 7'h0A;
      odReq = '0;
      stall = 8'h00;
      reset = 1'b1;
      repeat (4) @(negedge clk);
      reset = 1'b0;
      t_regs;
      t_inhibit;
      t_axis;
      t_codes;
      final_report;
   end
endmodule
bind eer_error_reporter eer_error_reporter_properties #(.INHIBIT_UNIT_CYCLES(INHIBIT_UNIT_CYCLES)) i_props (
   .clk(clk), .reset(reset), .cond(cond), .nodeId(nodeId), .odReq(odReq), .odAck(odAck), .odError(odError),
   .odRdata(odRdata), .emcyFrame(emcyFrame), .emcyValid(emcyValid), .emcyReady(emcyReady),
   .mfrErrorWord(mfrErrorWord), .errorByte(errorByte));
`default_nettype wire
